//--- hw/three_wire_serial_ch1.sv
// Three-wire serial channel 1: mode/clock register, shift register, clock
// generator, external-clock link logic and a receive FIFO.
// Assumes linkClk is the serial clock pin wired as a clock, idle high, and that
// the CPU strobes arrive synchronous to mclk.
//
// Overview of operation
// - Eight bits per block, MSB first, duplex
// - Select bits choose external or divided clock
// - Enable clear stops shifting, clears counter
// - Enable set allows shifting and end flag
// - Reset clears mode/clock register to zero
// - Mode register write-only; enable bit separately
// - Shift register write starts a transfer
// - Start needs enable, idle clock, clock high
// - Shift out on falling, capture rising
// - Stop after eight bits, set end flag
// - End flag never wakes from standby
// - Halted mode: shift register is plain storage
// - After reset pins are input-only ports
// - Shift register not cleared by reset
`timescale 1ns/100ps

module serial_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = store[rdPtr_reg];

  // Storage
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      store[wrPtr_reg] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop)
      begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module three_wire_serial_ch1
  import serial_ch1_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic modeWrite,
  input wire logic enableBitWrite,
  input wire logic enableBitValue,
  input wire logic shiftWrite,
  input wire logic [7:0] writeData,
  output logic [7:0] shiftReadData,
  output logic transferEndFlag,
  input wire logic endFlagClear,
  output logic transferBusy,
  input wire logic serialClockIn,
  output logic serialClockOut,
  output logic serialClockOe_n,
  output logic serialOutputOut,
  output logic serialOutputOe_n,
  input wire logic serialInputIn,
  output logic serialClockLevel,
  output logic serialInputLevel,
  output logic rxValid,
  input wire logic rxReady,
  output logic [7:0] rxData
);
  mode_type serial_mode_clock_reg;
  byte_type serial_shift_reg;
  byte_type txWord_reg;
  shift_state_type state_reg;
  logic [3:0] phase_reg;
  logic [3:0] bitCount_reg;
  logic sckOut_reg;
  logic soOut_reg;
  logic done_reg;
  logic endFlag_reg;
  logic [3:0] startCount_reg;
  logic sckSync1_reg;
  logic sckSync2_reg;
  logic siSync1_reg;
  logic siSync2_reg;
  logic [3:0] graySync1_reg;
  logic [3:0] graySync2_reg;
  logic [3:0] linkBin;
  logic linkRst1_reg;
  logic linkRst_reg;
  logic [3:0] edgeCount_reg;
  logic [3:0] edgeGray_reg;
  byte_type rxLink_reg;
  logic [3:0] fallIdx_reg;
  logic [3:0] linkOffset;
  logic linkSo;
  logic internalClock;
  logic [3:0] halfCycles;
  logic sckHigh;
  logic fifoReady;
  logic startOk;
  rx_word_type pushWord;
  rx_word_type popWord;

  assign internalClock = serial_mode_clock_reg.selUpper;
  assign halfCycles = serial_mode_clock_reg.selLower ? HALF_FAST : HALF_SLOW;
  assign sckHigh = internalClock ? sckOut_reg : sckSync2_reg;

  // Start conditions are checked at the write only
  assign startOk = serial_mode_clock_reg.enable && (state_reg == SHIFT_IDLE) && sckHigh
    && fifoReady;

  // Pin and link edge-count synchronisers
  always_ff @(posedge mclk)
  begin
    sckSync1_reg <= serialClockIn;
    sckSync2_reg <= sckSync1_reg;
    siSync1_reg <= serialInputIn;
    siSync2_reg <= siSync1_reg;
    graySync1_reg <= edgeGray_reg;
    graySync2_reg <= graySync1_reg;
  end

  always_comb
  begin
    linkBin[3] = graySync2_reg[3];
    for (int i = 2; i >= 0; i--)
    begin
      linkBin[i] = linkBin[i+1] ^ graySync2_reg[i];
    end
  end

  // Mode/clock register, write-only
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      serial_mode_clock_reg <= mode_type'(MODE_RESET);
    end
    else if (modeWrite)
    begin
      serial_mode_clock_reg <= mode_type'(writeData);
    end
    else if (enableBitWrite)
    begin
      serial_mode_clock_reg.enable <= enableBitValue;
    end
  end

  // Shift register and transfer engine
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= SHIFT_IDLE;
      phase_reg <= '0;
      bitCount_reg <= '0;
      sckOut_reg <= 1'b1;
      soOut_reg <= 1'b0;
      done_reg <= 1'b0;
      txWord_reg <= '0;
      startCount_reg <= '0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (!serial_mode_clock_reg.enable)
      begin
        state_reg <= SHIFT_IDLE;
        bitCount_reg <= '0;
        phase_reg <= '0;
        sckOut_reg <= 1'b1;
        if (shiftWrite)
        begin
          serial_shift_reg <= writeData;
        end
      end
      else
      begin
        unique case (state_reg)
          SHIFT_IDLE:
          begin
            if (shiftWrite)
            begin
              serial_shift_reg <= writeData;
              if (startOk)
              begin
                txWord_reg <= writeData;
                soOut_reg <= writeData[MSB_INDEX];
                startCount_reg <= linkBin;
                bitCount_reg <= '0;
                phase_reg <= '0;
                if (internalClock)
                begin
                  sckOut_reg <= 1'b0;
                  state_reg <= SHIFT_LOW;
                end
                else
                begin
                  state_reg <= SHIFT_EXT;
                end
              end
            end
          end
          SHIFT_LOW:
          begin
            if (phase_reg == halfCycles - 4'h1)
            begin
              phase_reg <= '0;
              sckOut_reg <= 1'b1;
              serial_shift_reg <= {serial_shift_reg[6:0], siSync2_reg};
              bitCount_reg <= bitCount_reg + 4'h1;
              state_reg <= SHIFT_HIGH;
            end
            else
            begin
              phase_reg <= phase_reg + 4'h1;
            end
          end
          SHIFT_HIGH:
          begin
            if (phase_reg == halfCycles - 4'h1)
            begin
              phase_reg <= '0;
              if (bitCount_reg == BLOCK_COUNT)
              begin
                state_reg <= SHIFT_IDLE;
                done_reg <= 1'b1;
              end
              else
              begin
                sckOut_reg <= 1'b0;
                soOut_reg <= serial_shift_reg[MSB_INDEX];
                state_reg <= SHIFT_LOW;
              end
            end
            else
            begin
              phase_reg <= phase_reg + 4'h1;
            end
          end
          SHIFT_EXT:
          begin
            if ((linkBin - startCount_reg) == BLOCK_COUNT)
            begin
              serial_shift_reg <= rxLink_reg;
              state_reg <= SHIFT_IDLE;
              done_reg <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // End-of-transfer flag; a set beats a clear, and nothing else reads it
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      endFlag_reg <= 1'b0;
    end
    else if (done_reg)
    begin
      endFlag_reg <= 1'b1;
    end
    else if (endFlagClear)
    begin
      endFlag_reg <= 1'b0;
    end
  end

  // Link-domain reset
  always_ff @(posedge linkClk)
  begin
    linkRst1_reg <= rst;
    linkRst_reg <= linkRst1_reg;
  end

  // Rising edges: count and capture the input line
  always_ff @(posedge linkClk)
  begin
    if (linkRst_reg)
    begin
      edgeCount_reg <= '0;
      edgeGray_reg <= '0;
    end
    else
    begin
      edgeCount_reg <= edgeCount_reg + 4'h1;
      edgeGray_reg <= (edgeCount_reg + 4'h1) ^ ((edgeCount_reg + 4'h1) >> 1);
    end
  end

  always_ff @(posedge linkClk)
  begin
    rxLink_reg <= {rxLink_reg[6:0], serialInputIn};
  end

  // Falling edges: remember how many bits have gone out
  always_ff @(negedge linkClk)
  begin
    if (linkRst_reg)
    begin
      fallIdx_reg <= LINK_IDX_RESET;
    end
    else
    begin
      fallIdx_reg <= edgeCount_reg;
    end
  end

  assign linkOffset = fallIdx_reg - startCount_reg;
  assign linkSo = (linkOffset == LINK_IDX_RESET) ? txWord_reg[MSB_INDEX]
    : txWord_reg[MSB_INDEX - linkOffset[2:0]];

  // Receive FIFO
  assign pushWord.data = serial_shift_reg;

  serial_rx_fifo #(
    .WIDTH(BLOCK_BITS),
    .DEPTH(FIFO_DEPTH)
  ) rxFifo (
    .mclk(mclk),
    .rst(rst),
    .inValid(done_reg),
    .inReady(fifoReady),
    .inData(pushWord),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(popWord)
  );

  // Outputs
  assign rxData = popWord.data;
  assign shiftReadData = serial_shift_reg;
  assign transferEndFlag = endFlag_reg;
  assign transferBusy = (state_reg != SHIFT_IDLE);
  assign serialClockOut = sckOut_reg;
  assign serialClockOe_n = !internalClock;
  assign serialOutputOut = (state_reg == SHIFT_EXT) ? linkSo : soOut_reg;
  assign serialOutputOe_n = !serial_mode_clock_reg.enable;
  assign serialClockLevel = sckSync2_reg;
  assign serialInputLevel = siSync2_reg;
endmodule

//--- hw/serial_ch1_pkg.sv
// Constants and types for the second three-wire serial channel.
// Assumes the core clock is fx and that the CPU bus strobes are one-cycle pulses.
package serial_ch1_pkg;

  // Block size, clock figures and receive FIFO depth
  localparam int BLOCK_BITS = 8;
  localparam int FX_HZ = 100000000;
  localparam int DIV_FAST = 8;
  localparam int DIV_SLOW = 16;
  localparam logic [3:0] HALF_FAST = 4'(DIV_FAST / 2);
  localparam logic [3:0] HALF_SLOW = 4'(DIV_SLOW / 2);
  localparam int RX_FIFO_DEPTH = 8;

  // Mode/clock register layout and reset value
  localparam int ENABLE_POS = 7;
  localparam int SEL_UPPER_POS = 1;
  localparam int SEL_LOWER_POS = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // Link-side idle marker and bit figures
  localparam logic [3:0] LINK_IDX_RESET = 4'hf;
  localparam logic [3:0] BLOCK_COUNT = 4'h8;
  localparam logic [2:0] MSB_INDEX = 3'h7;

  typedef logic [7:0] byte_type;

  typedef struct packed {
    logic enable;
    logic [4:0] spare;
    logic selUpper;
    logic selLower;
  } mode_type;

  typedef struct packed {
    byte_type data;
  } rx_word_type;

  typedef enum {SHIFT_IDLE, SHIFT_LOW, SHIFT_HIGH, SHIFT_EXT} shift_state_type;

endpackage

//--- verif/three_wire_serial_ch1_monitor.sv
// Checker for pin, flag and transfer timing of the serial channel.
// Assumes it is bound into the design top and sees its ports only.
`timescale 1ns/100ps
module three_wire_serial_ch1_monitor
  import serial_ch1_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic shiftWrite,
  input wire logic endFlagClear,
  input wire logic transferEndFlag,
  input wire logic transferBusy,
  input wire logic serialClockOut,
  input wire logic serialClockOe_n,
  input wire logic serialOutputOut,
  input wire logic serialOutputOe_n
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic [3:0] pulseCnt;
  always_ff @(posedge mclk)
  begin
    if (rst || !transferBusy)
      pulseCnt <= 4'h0;
    else if ($fell(serialClockOut))
      pulseCnt <= pulseCnt + 4'h1;
  end
  reset_idle_a:
    assert property ($fell(rst) |-> serialClockOe_n && serialOutputOe_n && serialClockOut && !transferBusy)
    else $error("pins not idle after reset");
  start_cause_a:
    assert property ($rose(transferBusy) |-> $past(shiftWrite))
    else $error("transfer began without a write");
  busy_enable_a:
    assert property (transferBusy |-> !serialOutputOe_n)
    else $error("shifting while halted");
  idle_high_a:
    assert property (!transferBusy && !$past(transferBusy) |-> serialClockOut)
    else $error("clock pin low while idle");
  pulse_eight_a:
    assert property ($fell(transferBusy) && !serialClockOe_n |-> pulseCnt == BLOCK_COUNT)
    else $error("clock pulse count wrong");
  end_flag_a:
    assert property ($fell(transferBusy) && !serialOutputOe_n |-> ##[0:4] transferEndFlag)
    else $error("end flag not set");
  low_half_a:
    assert property ($fell(serialClockOut) |-> !serialClockOut [*4])
    else $error("clock low half too short");
  out_hold_a:
    assert property (transferBusy && !serialClockOe_n && serialClockOut && $past(serialClockOut)
      |-> $stable(serialOutputOut))
    else $error("output moved while clock high");
  cover property ($fell(transferBusy) && !serialClockOe_n);
  cover property ($fell(transferBusy) && serialClockOe_n);
  cover property (transferEndFlag && endFlagClear);
endmodule
bind three_wire_serial_ch1 three_wire_serial_ch1_monitor i_three_wire_serial_ch1_monitor (.*);

//--- verif/serial_peer_model.sv
// Peer device on the three serial pins.
// Assumes devClk is the resolved level of the clock pin.
`timescale 1ns/100ps
module serial_peer_model (
  input wire logic devClk,
  input wire logic dutSo,
  input wire logic load,
  input wire logic extGo,
  input wire logic [7:0] txByte,
  output logic peerClk,
  output logic peerSi,
  output logic [7:0] gotByte
);
  logic [7:0] txReg;
  logic rose;
  initial peerClk = 1'b1;
  assign peerSi = txReg[7];
  always @(posedge load or devClk)
    if (load)
    begin
      txReg = txByte;
      rose = 1'b0;
    end
    else if (devClk)
    begin
      gotByte = {gotByte[6:0], dutSo};
      rose = 1'b1;
    end
    else if (rose)
      txReg = {txReg[6:0], ~txReg[0]};
  always @(posedge extGo)
    repeat (8)
    begin
      #62.5 peerClk = 1'b0;
      #62.5 peerClk = 1'b1;
    end
endmodule

//--- verif/three_wire_serial_ch1_tb_top.sv
// Self-checking bench: CPU strobes, peer on the pins, receive stream.
// Assumes the package, design, checker and peer model are compiled first.
`timescale 1ns/100ps
module three_wire_serial_ch1_tb_top
  import serial_ch1_pkg::*;
;
  logic mclk, rst, linkClk, modeWrite, enableBitWrite, enableBitValue, shiftWrite;
  logic endFlagClear, transferEndFlag, transferBusy, serialClockIn, serialClockOut;
  logic serialClockOe_n, serialOutputOut, serialOutputOe_n, serialInputIn;
  logic serialClockLevel, serialInputLevel, rxValid, rxReady, load, extGo, peerClk;
  logic [7:0] writeData, shiftReadData, rxData;
  logic [4:0] pins;
  byte_type peerTx, gotByte, tx;
  byte_type q[$];
  byte_type modes[3] = '{8'h83, 8'h82, 8'h80};
  int error_cnt, samples_checked, seedVal;

  assign linkClk = serialClockOe_n ? peerClk : serialClockOut;
  assign serialClockIn = linkClk;
  assign pins = {serialClockOe_n, serialOutputOe_n, serialClockOut, transferEndFlag, transferBusy};
  three_wire_serial_ch1 i_three_wire_serial_ch1 (.*);
  serial_peer_model i_serial_peer_model (.devClk(linkClk), .dutSo(serialOutputOut), .load(load),
    .extGo(extGo), .txByte(peerTx), .peerClk(peerClk), .peerSi(serialInputIn), .gotByte(gotByte));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic strobe(input int k, input byte_type d);
    writeData = d;
    {modeWrite, shiftWrite, endFlagClear, enableBitWrite} = 4'h8 >> k;
    cyc(1);
    {modeWrite, shiftWrite, endFlagClear, enableBitWrite} = 4'h0;
    cyc(1);
  endtask

  task automatic xfer(input byte_type m);
    int n;
    strobe(2, 8'h00);
    chk("transferEndFlag", 8'(transferEndFlag), 8'h00);
    tx = byte_type'($urandom);
    peerTx = byte_type'($urandom);
    q.push_back(peerTx);
    load = 1'b1;
    cyc(1);
    load = 1'b0;
    strobe(0, m);
    strobe(1, tx);
    chk("transferBusy", 8'(transferBusy), 8'h01);
    extGo = (m == 8'h80);
    cyc(1);
    extGo = 1'b0;
    for (n = 0; n < 3000 && transferBusy !== 1'b0; n++)
      cyc(1);
    chk("timeout", 8'(n == 3000), 8'h00);
    if (n == 3000)
      complete_run();
    cyc(2);
    chk("transferEndFlag", 8'(transferEndFlag), 8'h01);
    chk("gotByte", gotByte, tx);
    chk("shiftReadData", shiftReadData, peerTx);
    chk("serialInputLevel", 8'(serialInputLevel), 8'(peerTx[0]));
    chk("serialClockLevel", 8'(serialClockLevel), 8'h01);
  endtask

  always @(negedge mclk)
    if (rst === 1'b0 && rxValid === 1'b1 && rxReady === 1'b1)
      chk("rxData", rxData, q.size() != 0 ? q.pop_front() : 8'hxx);

  initial
  begin
    {rst, extGo, enableBitValue, rxReady, load} = 5'h14;
    {modeWrite, shiftWrite, endFlagClear, enableBitWrite} = 4'h0;
    writeData = 8'h00;
    peerTx = 8'h00;
    error_cnt = 0;
    samples_checked = 0;
    seedVal = $urandom(32'hdab7459c);
    cyc(1);
    extGo = 1'b1;
    cyc(100);
    extGo = 1'b0;
    cyc(4);
    rst = 1'b0;
    chk("pins", {3'h0, pins}, 8'h1c);
    $display("test reset done");
    tx = byte_type'($urandom);
    strobe(1, tx);
    chk("shiftReadData", shiftReadData, tx);
    chk("transferBusy", 8'(transferBusy), 8'h00);
    strobe(3, 8'h00);
    cyc(2);
    chk("transferBusy", 8'(transferBusy), 8'h00);
    chk("serialOutputOe_n", 8'(serialOutputOe_n), 8'h00);
    $display("test halted done");
    for (int i = 0; i < 8; i++)
      xfer(modes[i % 3]);
    strobe(1, tx);
    chk("transferBusy", 8'(transferBusy), 8'h00);
    $display("test fill done");
    rxReady = 1'b1;
    for (int i = 0; i < 50 && q.size() != 0; i++)
      cyc(1);
    chk("queueLeft", 8'(q.size()), 8'h00);
    $display("test drain done");
    xfer(8'h83);
    strobe(0, 8'h03);
    chk("transferEndFlag", 8'(transferEndFlag), 8'h01);
    cyc(3);
    $display("test hold done");
    complete_run();
  end
endmodule
